// ---- rtl/aor_pkg.sv ----
// Constants for the analog override register bank: offsets, field positions,
// reset values and converter reference levels.
// Assumes a 7-bit register address and 8-bit data carried by the serial port.
//
// Summary of operation
// - Override clear: fine calibration field reads back the internal calibration result.
// - Override set: host writes fine calibration, device uses written value.
// - Regulator override resets with smart reset and digital power-down enables set.
// - Digital power-down bit set powers down digital domain while idle.
// - Global override high drives blocks on and off; low only switches on.
// - Level register bit 6 crystal, bit 5 temperature sensor, bit 4 slow oscillator.
// - Level register holds 3-bit digital regulator level; bit 3 reserved.
// - Converter tuning one resets to 1d; reset, enables, tune override, value.
// - Converter reference: 000 0.5 V, 001 0.6 V, 010 0.7 V, 111 1.2 V.
// - Tuning two: bit 3 open loop, bit 4 common-mode enable, 7:5 reserved.
// - Gain control on: read automatic gain in 4:0; off: host sets gain.
// - Gain override one resets to 20: automatic gain on, manual fields zero.
// - Amplifier gain select bit 4 at zero chooses minimum gain of 5 dB.
// - Programmable amplifier gain field: 3 dB per step, 0 dB up to 24 dB.
// - Gain register two bit 7 makes gain control ignore preamble detection.
// - Gain register two bit 6 slows gain increase; gain reduction unchanged.
// - Gain compensation field 5:2 smooths signal strength on amplifier gain switch.
// - Gain register two bits 1:0 set window comparator reference adjustment.

package aor_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [6:0] ADDR_RC_FINE    = 7'h64;
  localparam logic [6:0] ADDR_REG_OVR    = 7'h65;
  localparam logic [6:0] ADDR_REG_LEVEL  = 7'h66;
  localparam logic [6:0] ADDR_CONV_ONE   = 7'h67;
  localparam logic [6:0] ADDR_CONV_TWO   = 7'h68;
  localparam logic [6:0] ADDR_GAIN_ONE   = 7'h69;
  localparam logic [6:0] ADDR_GAIN_TWO   = 7'h6a;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_RC_FINE     = 8'h00;
  localparam logic [7:0] RST_REG_OVR     = 8'h81;
  localparam logic [7:0] RST_REG_LEVEL   = 8'h00;
  localparam logic [7:0] RST_CONV_ONE    = 8'h1d;
  localparam logic [7:0] RST_CONV_TWO    = 8'h00;
  localparam logic [7:0] RST_GAIN_ONE    = 8'h20;
  localparam logic [7:0] RST_GAIN_TWO    = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_OVR_BIT       = 7;
  localparam int POS_SPOR          = 7;
  localparam int POS_DIG_PWDN      = 0;
  localparam int POS_LVL_XTAL      = 6;
  localparam int POS_LVL_TEMP      = 5;
  localparam int POS_LVL_SLOW      = 4;
  localparam int POS_CONV_RST      = 7;
  localparam int POS_CONV_REFDAC   = 6;
  localparam int POS_CONV_EN       = 5;
  localparam int POS_CONV_TUNE_OV  = 4;
  localparam int POS_CONV_VCM      = 4;
  localparam int POS_CONV_OLOOP    = 3;
  localparam int POS_AGC_EN        = 5;
  localparam int POS_LNA_SEL       = 4;
  localparam int POS_IGN_PRE       = 7;
  localparam int POS_SLOW_RISE     = 6;

  // ----------------------------------------
  // Converter reference levels and gain steps
  // ----------------------------------------
  localparam logic [10:0] REF_MV_000     = 11'h1f4;
  localparam logic [10:0] REF_MV_001     = 11'h258;
  localparam logic [10:0] REF_MV_010     = 11'h2bc;
  localparam logic [10:0] REF_MV_111     = 11'h4b0;
  localparam logic [5:0]  LNA_MIN_DB     = 6'h05;
  localparam logic [5:0]  PGA_STEP_DB    = 6'h03;
  localparam logic [5:0]  PGA_MAX_DB     = 6'h18;

endpackage

// ---- rtl/aor_spi_slave.sv ----
// Serial port slave: one write/read flag, seven address bits, eight data bits.
// Assumes SCLK, NSEL and SDI are synchronous to the system clock and far slower.
`timescale 1ns/1ns

module aor_spi_slave (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Serial pins
  input  wire logic       i_sclk,
  input  wire logic       i_nsel,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  // Register side
  output logic [6:0]      o_addr,
  output logic            o_wr,
  output logic [7:0]      o_wdata,
  input  wire logic [7:0] i_rdata
);

  typedef struct packed {
    logic       sclk;
    logic [4:0] cnt;
    logic       is_wr;
    logic [6:0] addr;
    logic [6:0] rx;
    logic [7:0] tx;
    logic       oe;
    logic       wr;
    logic [7:0] wdata;
  } aor_spi_t;

  aor_spi_t s_q;
  aor_spi_t s_d;

  logic rise;
  logic fall;

  assign rise = i_sclk & ~s_q.sclk;
  assign fall = ~i_sclk & s_q.sclk;

  always_comb begin
    s_d      = s_q;
    s_d.sclk = i_sclk;
    s_d.wr   = 1'b0;
    if (i_nsel) begin
      s_d.cnt = 5'h00;
      s_d.oe  = 1'b0;
    end else begin
      if (rise && s_q.cnt != 5'h10) begin
        s_d.rx  = {s_q.rx[5:0], i_sdi};
        s_d.cnt = s_q.cnt + 5'h01;
        if (s_q.cnt == 5'h00) begin
          s_d.is_wr = i_sdi;
        end else if (s_q.cnt < 5'h08) begin
          s_d.addr = {s_q.addr[5:0], i_sdi};
        end else if (s_q.cnt == 5'h0f && s_q.is_wr) begin
          s_d.wr    = 1'b1;
          s_d.wdata = {s_q.rx, i_sdi};
        end
      end
      // Data leaves on the falling edge so it is stable at the master's rising edge
      if (fall && !s_q.is_wr) begin
        if (s_q.cnt == 5'h08) begin
          s_d.tx = i_rdata;
          s_d.oe = 1'b1;
        end else if (s_q.cnt > 5'h08) begin
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sdo    = s_q.tx[7];
  assign o_sdo_oe = s_q.oe;
  assign o_addr   = s_q.addr;
  assign o_wr     = s_q.wr;
  assign o_wdata  = s_q.wdata;

endmodule

// ---- rtl/aor_top.sv ----
// Analog override register bank with serial port access and the control
// outputs that steer the oscillator, regulators, converter and gain loop.
// Assumes serial pins synchronous to I_CLK; analog blocks sit outside.
`timescale 1ns/1ns

module aor_top #(
  parameter logic [5:0] LNA_HIGH_DB = 6'h19
) (
  // Clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RESETN,
  // Serial port
  input  wire logic        I_SCLK,
  input  wire logic        I_NSEL,
  input  wire logic        I_SDI,
  output logic             O_SDO,
  output logic             O_SDO_OE,
  // Internal results and requests
  input  wire logic [6:0]  I_RC_FINE_CAL,
  input  wire logic [6:0]  I_AUTO_EN,
  input  wire logic        I_IDLE,
  input  wire logic [3:0]  I_CONV_TUNE_AUTO,
  input  wire logic [4:0]  I_AGC_GAIN,
  // Oscillator and regulators
  output logic [6:0]       O_RC_FINE,
  output logic             O_SMART_POR_EN,
  output logic [6:0]       O_BLOCK_EN,
  output logic             O_DIG_PWDN,
  output logic             O_TEMP_SENSE_EN,
  output logic             O_SLOW_OSCILLATOR_ON,
  output logic [2:0]       O_DIG_LEVEL,
  // Converter
  output logic             O_CONV_RESET,
  output logic             O_CONV_REFDAC_EN,
  output logic             O_CONV_EN,
  output logic [3:0]       O_CONV_TUNE,
  output logic             O_CONV_VCM_EN,
  output logic             O_CONV_OPEN_LOOP,
  output logic [2:0]       O_CONV_REF_SEL,
  output logic [10:0]      O_CONV_REF_MV,
  // Gain control
  output logic             O_AGC_EN,
  output logic             O_LNA_HIGH,
  output logic [3:0]       O_PGA_GAIN,
  output logic [5:0]       O_GAIN_DB,
  output logic             O_AGC_IGNORE_PREAMBLE,
  output logic             O_AGC_SLOW_RISE,
  output logic [3:0]       O_LNA_COMP,
  output logic [1:0]       O_PGA_WINDOW_REF
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Block enable order: xtal, bias, vco, if, rf, pll, digital regulator
  typedef struct packed {
    logic [7:0]  rc_fine;
    logic [7:0]  reg_ovr;
    logic [6:0]  reg_lvl;
    logic [7:0]  conv_one;
    logic [4:0]  conv_two;
    logic [5:0]  gain_one;
    logic [7:0]  gain_two;
    logic [6:0]  rc_out;
    logic [6:0]  blk_en;
    logic        dig_pwdn;
    logic [3:0]  tune_out;
    logic [10:0] ref_mv;
    logic [4:0]  gain_out;
    logic [5:0]  gain_db;
  } aor_state_t;

  aor_state_t s_q;
  aor_state_t s_d;

  logic [6:0] spi_addr;
  logic       spi_wr;
  logic [7:0] spi_wdata;
  logic [7:0] rd_data;
  logic [6:0] ovr_en;
  logic [5:0] pga_db;

  // ----------------------------------------
  // Serial port
  // ----------------------------------------
  aor_spi_slave u_spi (
    .i_clk    (I_CLK),
    .i_resetn (I_RESETN),
    .i_sclk   (I_SCLK),
    .i_nsel   (I_NSEL),
    .i_sdi    (I_SDI),
    .o_sdo    (O_SDO),
    .o_sdo_oe (O_SDO_OE),
    .o_addr   (spi_addr),
    .o_wr     (spi_wr),
    .o_wdata  (spi_wdata),
    .i_rdata  (rd_data)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Unmapped addresses read zero
  always_comb begin
    case (spi_addr)
      aor_pkg::ADDR_RC_FINE: begin
        rd_data = s_q.rc_fine[aor_pkg::POS_OVR_BIT] ? s_q.rc_fine :
                  {1'b0, I_RC_FINE_CAL};
      end
      aor_pkg::ADDR_REG_OVR: begin
        rd_data = s_q.reg_ovr;
      end
      aor_pkg::ADDR_REG_LEVEL: begin
        rd_data = {s_q.reg_lvl[6:3], 1'b0, s_q.reg_lvl[2:0]};
      end
      aor_pkg::ADDR_CONV_ONE: begin
        rd_data = s_q.conv_one;
      end
      aor_pkg::ADDR_CONV_TWO: begin
        rd_data = {3'h0, s_q.conv_two};
      end
      aor_pkg::ADDR_GAIN_ONE: begin
        rd_data = s_q.gain_one[aor_pkg::POS_AGC_EN] ? {3'h1, I_AGC_GAIN} :
                  {2'h0, s_q.gain_one};
      end
      aor_pkg::ADDR_GAIN_TWO: begin
        rd_data = s_q.gain_two;
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    if (spi_wr) begin
      case (spi_addr)
        aor_pkg::ADDR_RC_FINE: begin
          s_d.rc_fine = spi_wdata;
        end
        aor_pkg::ADDR_REG_OVR: begin
          s_d.reg_ovr = spi_wdata;
        end
        aor_pkg::ADDR_REG_LEVEL: begin
          s_d.reg_lvl = {spi_wdata[7:4], spi_wdata[2:0]};
        end
        aor_pkg::ADDR_CONV_ONE: begin
          s_d.conv_one = spi_wdata;
        end
        aor_pkg::ADDR_CONV_TWO: begin
          s_d.conv_two = spi_wdata[4:0];
        end
        aor_pkg::ADDR_GAIN_ONE: begin
          s_d.gain_one = spi_wdata[5:0];
        end
        aor_pkg::ADDR_GAIN_TWO: begin
          s_d.gain_two = spi_wdata;
        end
        default: begin
          s_d.gain_two = s_q.gain_two;
        end
      endcase
    end

    // Fine calibration in use
    s_d.rc_out = s_q.rc_fine[aor_pkg::POS_OVR_BIT] ? s_q.rc_fine[6:0] : I_RC_FINE_CAL;

    // Without global override a set bit only adds to the automatic request
    s_d.blk_en = s_q.reg_lvl[6] ? ovr_en : (ovr_en | I_AUTO_EN);
    s_d.dig_pwdn = s_q.reg_ovr[aor_pkg::POS_DIG_PWDN] & I_IDLE;

    s_d.tune_out = s_q.conv_one[aor_pkg::POS_CONV_TUNE_OV] ? s_q.conv_one[3:0] : I_CONV_TUNE_AUTO;

    // Codes 011 to 110 have no defined level and report zero
    case (s_q.conv_two[2:0])
      3'h0: begin
        s_d.ref_mv = aor_pkg::REF_MV_000;
      end
      3'h1: begin
        s_d.ref_mv = aor_pkg::REF_MV_001;
      end
      3'h2: begin
        s_d.ref_mv = aor_pkg::REF_MV_010;
      end
      3'h7: begin
        s_d.ref_mv = aor_pkg::REF_MV_111;
      end
      default: begin
        s_d.ref_mv = 11'h000;
      end
    endcase

    s_d.gain_out = s_q.gain_one[aor_pkg::POS_AGC_EN] ? I_AGC_GAIN : s_q.gain_one[4:0];
    s_d.gain_db  = (s_q.gain_out[4] ? LNA_HIGH_DB : aor_pkg::LNA_MIN_DB) + pga_db;
  end

  // Order matches the block enable bundle
  assign ovr_en = {s_q.reg_lvl[5], s_q.reg_ovr[6:1]};

  // Steps above the ceiling clamp rather than wrap
  always_comb begin
    if (s_q.gain_out[3:0] > 4'h8) begin
      pga_db = aor_pkg::PGA_MAX_DB;
    end else begin
      pga_db = 6'(s_q.gain_out[3:0] * aor_pkg::PGA_STEP_DB);
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      s_q          <= '0;
      s_q.rc_fine  <= aor_pkg::RST_RC_FINE;
      s_q.reg_ovr  <= aor_pkg::RST_REG_OVR;
      s_q.reg_lvl  <= 7'(aor_pkg::RST_REG_LEVEL);
      s_q.conv_one <= aor_pkg::RST_CONV_ONE;
      s_q.conv_two <= 5'(aor_pkg::RST_CONV_TWO);
      s_q.gain_one <= 6'(aor_pkg::RST_GAIN_ONE);
      s_q.gain_two <= aor_pkg::RST_GAIN_TWO;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_RC_FINE             = s_q.rc_out;
  assign O_SMART_POR_EN        = s_q.reg_ovr[aor_pkg::POS_SPOR];
  assign O_BLOCK_EN            = s_q.blk_en;
  assign O_DIG_PWDN            = s_q.dig_pwdn;
  assign O_TEMP_SENSE_EN       = s_q.reg_lvl[aor_pkg::POS_LVL_TEMP - 1];
  assign O_SLOW_OSCILLATOR_ON  = s_q.reg_lvl[aor_pkg::POS_LVL_SLOW - 1];
  assign O_DIG_LEVEL           = s_q.reg_lvl[2:0];
  assign O_CONV_RESET          = s_q.conv_one[aor_pkg::POS_CONV_RST];
  assign O_CONV_REFDAC_EN      = s_q.conv_one[aor_pkg::POS_CONV_REFDAC];
  assign O_CONV_EN             = s_q.conv_one[aor_pkg::POS_CONV_EN];
  assign O_CONV_TUNE           = s_q.tune_out;
  assign O_CONV_VCM_EN         = s_q.conv_two[aor_pkg::POS_CONV_VCM];
  assign O_CONV_OPEN_LOOP      = s_q.conv_two[aor_pkg::POS_CONV_OLOOP];
  assign O_CONV_REF_SEL        = s_q.conv_two[2:0];
  assign O_CONV_REF_MV         = s_q.ref_mv;
  assign O_AGC_EN              = s_q.gain_one[aor_pkg::POS_AGC_EN];
  assign O_LNA_HIGH            = s_q.gain_out[aor_pkg::POS_LNA_SEL];
  assign O_PGA_GAIN            = s_q.gain_out[3:0];
  assign O_GAIN_DB             = s_q.gain_db;
  assign O_AGC_IGNORE_PREAMBLE = s_q.gain_two[aor_pkg::POS_IGN_PRE];
  assign O_AGC_SLOW_RISE       = s_q.gain_two[aor_pkg::POS_SLOW_RISE];
  assign O_LNA_COMP            = s_q.gain_two[5:2];
  assign O_PGA_WINDOW_REF      = s_q.gain_two[1:0];

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  a_fine_readback: assert property (
    !s_q.rc_fine[7] |=> O_RC_FINE == $past(I_RC_FINE_CAL))
    else $error("Fine calibration output ignores internal result");

  a_fine_override: assert property (
    spi_wr && spi_addr == aor_pkg::ADDR_RC_FINE && spi_wdata[7]
    |=> ##1 O_RC_FINE == $past(spi_wdata[6:0], 2))
    else $error("Written fine calibration not applied");

  a_reg_ovr_reset: assert property (
    $rose(I_RESETN) |-> s_q.reg_ovr == 8'h81)
    else $error("Regulator override reset value wrong");

  a_dig_powerdown: assert property (
    s_q.reg_ovr[0] && I_IDLE |=> O_DIG_PWDN)
    else $error("Digital domain not powered down in idle");

  a_only_switch_on: assert property (
    !s_q.reg_lvl[6] && I_AUTO_EN[6] |=> O_BLOCK_EN[6])
    else $error("Automatic request lost without global override");

  a_override_off: assert property (
    s_q.reg_lvl[6] && !s_q.reg_lvl[5] |=> !O_BLOCK_EN[6])
    else $error("Global override failed to switch block off");

  a_level_reserved: assert property (
    spi_addr == aor_pkg::ADDR_REG_LEVEL |-> rd_data[3] == 1'b0)
    else $error("Reserved level bit reads nonzero");

  a_conv_reset: assert property (
    $rose(I_RESETN) |-> s_q.conv_one == 8'h1d)
    else $error("Converter tuning one reset value wrong");

  a_ref_level: assert property (
    s_q.conv_two[2:0] == 3'h7 |=> O_CONV_REF_MV == 11'd1200)
    else $error("Reference level for code 111 wrong");

  a_agc_result: assert property (
    spi_addr == aor_pkg::ADDR_GAIN_ONE && s_q.gain_one[5] |-> rd_data[4:0] == I_AGC_GAIN)
    else $error("Automatic gain result not readable");

  a_agc_reset: assert property (
    $rose(I_RESETN) |-> s_q.gain_one == 6'h20)
    else $error("Gain override one reset value wrong");

  a_gain_min: assert property (
    !O_LNA_HIGH && O_PGA_GAIN == 4'h0 |=> O_GAIN_DB == 6'd5)
    else $error("Minimum gain is not 5 dB");

  a_gain_ceiling: assert property (
    !O_LNA_HIGH && O_PGA_GAIN == 4'h8 |=> O_GAIN_DB == 6'd29)
    else $error("Amplifier gain step wrong");

  a_reserved_write: assert property (
    spi_wr && spi_addr == aor_pkg::ADDR_CONV_TWO |=> s_q.conv_two == $past(spi_wdata[4:0]))
    else $error("Converter tuning two write wrong");

  a_pwdn_release: assert property (
    !(s_q.reg_ovr[0] && I_IDLE) |=> !O_DIG_PWDN)
    else $error("Digital domain powered down outside idle");

  a_override_on: assert property (
    s_q.reg_lvl[6] && s_q.reg_lvl[5] |=> O_BLOCK_EN[6])
    else $error("Global override failed to switch block on");

  a_tune_override: assert property (
    s_q.conv_one[4] |=> O_CONV_TUNE == $past(s_q.conv_one[3:0]))
    else $error("Converter tune override value not applied");

  a_ref_low: assert property (
    s_q.conv_two[2:0] == 3'h0 |=> O_CONV_REF_MV == 11'd500)
    else $error("Reference level for code 000 wrong");

  c_fine_override:  cover property (spi_wr && spi_addr == aor_pkg::ADDR_RC_FINE && spi_wdata[7]);
  c_manual_gain:    cover property (spi_wr && spi_addr == aor_pkg::ADDR_GAIN_ONE && !spi_wdata[5]);
  c_ref_high:       cover property (s_q.conv_two[2:0] == 3'h7);
  c_idle_powerdown: cover property (O_DIG_PWDN);

endmodule

// ---- testbench/aor_host_model.sv ----
// Host side of the serial port: a master that sends 16-bit frames.
// Assumes it is stepped on falling edges of the device clock.
`timescale 1ns/1ns

module aor_host_model (
  // Clock
  input  wire logic i_clk,
  // Serial pins
  input  wire logic i_sdo,
  output logic      o_sclk,
  output logic      o_nsel,
  output logic      o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_nsel = 1'b1;
    o_sdi  = 1'b0;
  end

  // Half period in clocks picks a prompt or slow host; nbits under 16 cuts the frame
  task automatic xfer(input logic wr, input logic [6:0] addr, input logic [7:0] wdata,
                      input int half, input int nbits, output logic [7:0] rdata);
    logic [15:0] frame;
    frame = {wr, addr, wdata};
    rdata = 8'h00;
    @(negedge i_clk);
    o_nsel = 1'b0;
    for (int b = 15; b > 15 - nbits; b--) begin
      // Data line is meaningless in the read phase, so keep it moving
      o_sdi = (wr || b > 7) ? frame[b] : ~o_sdi;
      repeat (half) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (half) @(negedge i_clk);
      if (b < 8) rdata[b] = i_sdo;
      o_sclk = 1'b0;
    end
    repeat (half) @(negedge i_clk);
    o_nsel = 1'b1;
    o_sdi  = ~o_sdi;
    repeat (2) @(negedge i_clk);
  endtask
endmodule

// ---- testbench/test_analog_override_registers.sv ----
// Self-checking bench for the analog override register bank.
// Assumes the host model drives the serial pins; analog inputs are random.
`timescale 1ns/1ns

module test_analog_override_registers;
  localparam logic [5:0] LNA_HI = 6'h19;
  localparam logic [7:0] WMASK [7] = '{8'hff, 8'hff, 8'hf7, 8'hff, 8'h1f, 8'h3f, 8'hff};
  localparam logic [7:0] RSTV [7]  = '{8'h00, 8'h81, 8'h00, 8'h1d, 8'h00, 8'h20, 8'h00};

  logic        clk, resetn, sclk, nsel, sdi, sdo, sdo_oe, idle;
  logic [6:0]  rc_cal, auto_en, rc_fine, block_en;
  logic [3:0]  tune_auto, ctune, pga, comp;
  logic [4:0]  agc_gain;
  logic        spor, pwdn, temp, slow, crst, cref, cen, vcm, oloop, agcen, lna, ign, srise;
  logic [2:0]  lvl, rsel;
  logic [10:0] rmv;
  logic [5:0]  gdb;
  logic [1:0]  wref;
  logic [7:0]  sh [7];
  logic [7:0]  d;
  int          error_cnt;
  int          n_tests;

  aor_top #(.LNA_HIGH_DB(LNA_HI)) i_dut (
    .I_CLK(clk), .I_RESETN(resetn), .I_SCLK(sclk), .I_NSEL(nsel), .I_SDI(sdi),
    .O_SDO(sdo), .O_SDO_OE(sdo_oe), .I_RC_FINE_CAL(rc_cal), .I_AUTO_EN(auto_en),
    .I_IDLE(idle), .I_CONV_TUNE_AUTO(tune_auto), .I_AGC_GAIN(agc_gain),
    .O_RC_FINE(rc_fine), .O_SMART_POR_EN(spor), .O_BLOCK_EN(block_en), .O_DIG_PWDN(pwdn),
    .O_TEMP_SENSE_EN(temp), .O_SLOW_OSCILLATOR_ON(slow), .O_DIG_LEVEL(lvl),
    .O_CONV_RESET(crst), .O_CONV_REFDAC_EN(cref), .O_CONV_EN(cen), .O_CONV_TUNE(ctune),
    .O_CONV_VCM_EN(vcm), .O_CONV_OPEN_LOOP(oloop), .O_CONV_REF_SEL(rsel), .O_CONV_REF_MV(rmv),
    .O_AGC_EN(agcen), .O_LNA_HIGH(lna), .O_PGA_GAIN(pga), .O_GAIN_DB(gdb),
    .O_AGC_IGNORE_PREAMBLE(ign), .O_AGC_SLOW_RISE(srise), .O_LNA_COMP(comp),
    .O_PGA_WINDOW_REF(wref)
  );

  // Released data line shows the inverse, so a late or missing enable corrupts reads
  aor_host_model i_host (
    .i_clk(clk), .i_sdo(sdo_oe ? sdo : ~sdo), .o_sclk(sclk), .o_nsel(nsel), .o_sdi(sdi)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // --------------------------------------
  // Expectations and checks
  // --------------------------------------
  function automatic logic [7:0] exp_rd(input logic [6:0] a);
    case (a)
      7'h64: exp_rd = sh[0][7] ? sh[0] : {1'b0, rc_cal};
      7'h69: exp_rd = sh[5][5] ? {3'b001, agc_gain} : sh[5];
      7'h65, 7'h66, 7'h67, 7'h68, 7'h6a: exp_rd = sh[a - 7'h64];
      default: exp_rd = 8'h00;
    endcase
  endfunction

  function automatic logic [10:0] ref_mv(input logic [2:0] c);
    case (c)
      3'h0: ref_mv = 11'd500;
      3'h1: ref_mv = 11'd600;
      3'h2: ref_mv = 11'd700;
      3'h7: ref_mv = 11'd1200;
      default: ref_mv = 11'h000;
    endcase
  endfunction

  function automatic logic [5:0] gain_db(input logic [4:0] g);
    gain_db = (g[4] ? LNA_HI : 6'h05) + ((g[3:0] > 4'h8) ? 6'h18 : 6'(g[3:0]) * 6'h03);
  endfunction

  task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] unused;
    i_host.xfer(1'b1, a, v, 2 + $urandom_range(3), 16, unused);
    if (a >= 7'h64 && a <= 7'h6a) sh[a - 7'h64] = v & WMASK[a - 7'h64];
  endtask

  task automatic rd(input logic [6:0] a);
    logic [7:0] v;
    i_host.xfer(1'b0, a, 8'h00, 2 + $urandom_range(3), 16, v);
    chk(v, exp_rd(a));
    chk(sdo_oe, 1'b0);
  endtask

  // New analog inputs, then let derived outputs settle
  task automatic stir;
    @(negedge clk);
    rc_cal    = 7'($urandom);
    auto_en   = 7'($urandom);
    idle      = 1'($urandom);
    tune_auto = 4'($urandom);
    agc_gain  = 5'($urandom);
    repeat (4) @(negedge clk);
  endtask

  task automatic chk_out;
    logic [6:0] ovr;
    logic [4:0] g;
    ovr = {sh[2][6], sh[1][6:1]};
    g   = sh[5][5] ? agc_gain : sh[5][4:0];
    chk(rc_fine, sh[0][7] ? sh[0][6:0] : rc_cal);
    chk(spor, sh[1][7]);
    chk(pwdn, sh[1][0] & idle);
    chk(block_en, sh[2][7] ? ovr : (ovr | auto_en));
    chk({temp, slow, lvl}, {sh[2][5:4], sh[2][2:0]});
    chk({crst, cref, cen, ctune}, {sh[3][7:5], sh[3][4] ? sh[3][3:0] : tune_auto});
    chk({vcm, oloop, rsel}, sh[4][4:0]);
    chk(rmv, ref_mv(sh[4][2:0]));
    chk({agcen, lna, pga}, {sh[5][5], g});
    chk(gdb, gain_db(g));
    chk({ign, srise, comp, wref}, sh[6]);
  endtask

  task automatic do_reset;
    @(negedge clk);
    resetn = 1'b0;
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    sh = RSTV;
    stir();
    chk_out();
    for (int i = 0; i < 7; i++) rd(7'h64 + 7'(i));
    $display("test reset done");
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // --------------------------------------
  // Main sequence
  // --------------------------------------
  initial begin
    error_cnt = 0;
    n_tests   = 0;
    void'($urandom(32'hc230));
    resetn = 1'b0;
    {rc_cal, auto_en, idle, tune_auto, agc_gain} = '0;
    do_reset();
    // All ones, all zeros, then random data to every register
    for (int i = 0; i < 35; i++) begin
      d = (i < 7) ? 8'hff : (i < 14) ? 8'h00 : 8'($urandom);
      wr(7'h64 + 7'(i % 7), d);
      stir();
      chk_out();
      rd(7'h64 + 7'(i % 7));
    end
    $display("test random access done");
    // Every reference code and every manual gain code
    for (int c = 0; c < 32; c++) begin
      wr(7'h68, {3'($urandom), 5'(c)});
      wr(7'h69, {3'b000, 5'(c)});
      stir();
      chk_out();
    end
    $display("test code sweep done");
    // Short frame and unmapped places change nothing
    wr(7'h6a, 8'h5a);
    i_host.xfer(1'b1, 7'h6a, 8'ha5, 3, 12, d);
    rd(7'h6a);
    wr(7'h6b, 8'hff);
    rd(7'h6b);
    wr(7'h63, 8'hff);
    rd(7'h63);
    stir();
    chk_out();
    $display("test refused frames done");
    do_reset();
    results();
  end

  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    $display("CHECK FAILED at %0t: run too long", $time);
    results();
  end
endmodule
